/* rtl/dfm_meter.sv */
// Eight-terminal digital input frequency meter with status sampling.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dfm_defines.svh"
// Contract
// R1 - Interval count is snapshot minus previous snapshot.
// R2 - Plain mode: pulses per interval over length.
// R3 - Period longer than interval marks result invalid.
// R4 - Keep pulse, reference and interval counters.
// R5 - Latch reference count at selected input edge.
// R6 - Latch pulse and interval counts at end.
// R7 - Reciprocal: pulses over reference counts times fref.
// R8 - Wrapping 32-bit counters never overflow per interval.
// R9 - Quadrature pair gives rotation direction.
// R10 - Channel N pulse on N, direction N+4.
// R11 - Sample status inputs continuously, read as bits.
// R12 - Low input voltage reads as logic one.
// R13 - Four frequency channels, eight status inputs.
// R14 - Any function mix within eight terminals accepted.
// R15 - Fast variant: two channels, 1 or 2 ms.
// R16 - Fast variant reference clock is 48 MHz.
// R17 - Interval counter restarts without stopping counters.
module dfm_meter (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic [7:0]            term_in,
  input  wire logic [`DFM_ADDR_W-1:0] addr,
  input  wire logic [31:0]           wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic [31:0]                rdata,
  output logic [7:0]                 status_out,
  output logic                       irq
);
  dfm_pkg::dfm_state_s state_reg;
  dfm_pkg::dfm_state_s state_next;

  // Selects the pulse terminal of a channel; fast mode uses 0 and 4.
  function automatic logic [2:0] pulse_term(input logic [1:0] ch,
                                            input logic       fast);
    if (fast) begin
      pulse_term = (ch == 2'h1) ? 3'h4 : 3'h0; // R15
    end else begin
      pulse_term = {1'b0, ch}; // R10
    end
  endfunction

  function automatic logic [2:0] dir_term(input logic [1:0] ch,
                                          input logic       fast);
    if (fast) begin
      dir_term = (ch == 2'h1) ? 3'h5 : 3'h1; // R15
    end else begin
      dir_term = {1'b1, ch}; // R10
    end
  endfunction

  // Fast mode leaves only the first channel, or the first two.
  function automatic logic chan_active(
      input logic [1:0]         ch,
      input dfm_pkg::dfm_ctrl_s c);
    logic in_fast;
    in_fast = (ch == 2'h0) || ((ch == 2'h1) && c.fast_two);
    chan_active = c.en[ch] && (!c.fast || in_fast); // R13
  endfunction

  function automatic logic is_chan_addr(
      input logic [`DFM_ADDR_W-1:0] a);
    is_chan_addr = (a >= `DFM_REG_CH_BASE) &&
                   (a < (`DFM_REG_CH_BASE + 8'h40));
  endfunction

  function automatic logic [1:0] chan_of_addr(
      input logic [`DFM_ADDR_W-1:0] a);
    logic [`DFM_ADDR_W-1:0] off;
    off = a - `DFM_REG_CH_BASE;
    chan_of_addr = off[5:4];
  endfunction

  function automatic dfm_pkg::dfm_word_t chan_field(
      input dfm_pkg::dfm_snap_s s,
      input logic [1:0]         sel);
    case (sel)
      `DFM_CH_PULSE: begin
        chan_field = s.pulse;
      end
      `DFM_CH_REFCNT: begin
        chan_field = s.refcnt;
      end
      `DFM_CH_INTERVAL: begin
        chan_field = s.interval;
      end
      default: begin
        chan_field = s.edge_ref;
      end
    endcase
  endfunction

  function automatic dfm_pkg::dfm_word_t ctrl_pack(
      input dfm_pkg::dfm_ctrl_s c);
    dfm_pkg::dfm_word_t w;
    w = 32'h00000000;
    w[`DFM_CTRL_EN_LSB +: 4]    = c.en;
    w[`DFM_CTRL_FALL_LSB +: 4]  = c.fall;
    w[`DFM_CTRL_RECIP_LSB +: 4] = c.recip;
    w[`DFM_CTRL_FAST_LSB]       = c.fast;
    w[`DFM_CTRL_FAST2_BIT]      = c.fast_two;
    ctrl_pack = w;
  endfunction

  function automatic dfm_pkg::dfm_ctrl_s ctrl_unpack(
      input dfm_pkg::dfm_word_t w);
    dfm_pkg::dfm_ctrl_s c;
    c.en       = w[`DFM_CTRL_EN_LSB +: 4];
    c.fall     = w[`DFM_CTRL_FALL_LSB +: 4];
    c.recip    = w[`DFM_CTRL_RECIP_LSB +: 4];
    c.fast     = w[`DFM_CTRL_FAST_LSB];
    c.fast_two = w[`DFM_CTRL_FAST2_BIT];
    ctrl_unpack = c;
  endfunction

  // Differences are modulo 2^32, so a counter wrap inside the
  // interval does not disturb the result.
  function automatic dfm_pkg::dfm_snap_s take_snap(
      input dfm_pkg::dfm_word_t pulse_now,
      input dfm_pkg::dfm_word_t pulse_old,
      input dfm_pkg::dfm_word_t edge_now,
      input dfm_pkg::dfm_word_t edge_old,
      input dfm_pkg::dfm_word_t cnt,
      input logic               dir);
    dfm_pkg::dfm_snap_s s;
    s.pulse    = pulse_now - pulse_old; // R1
    s.refcnt   = edge_now - edge_old; // R7
    s.interval = cnt + 32'h00000001; // R6
    s.edge_ref = edge_now;
    s.dir      = dir;
    // No edge at all means the period outlasts the interval.
    s.valid    = (pulse_now != pulse_old); // R3
    take_snap  = s;
  endfunction

  logic [7:0]         rise_edge;
  logic [7:0]         fall_edge;
  logic [3:0]         chan_on;
  logic [3:0]         chan_hit;
  logic [3:0]         chan_dir;
  logic               fast_tick;
  logic               ivl_end;
  dfm_pkg::dfm_word_t fast_len;

  always_comb begin
    fast_len = state_reg.ctrl.fast_two ? 32'(`DFM_FAST_2IN_CYC)
                                       : 32'(`DFM_FAST_1IN_CYC); // R15
    fast_tick = state_reg.ctrl.fast &&
                (state_reg.ivl_cnt >= fast_len - 32'h00000001);
    if (state_reg.ctrl.fast) begin
      ivl_end = fast_tick;
    end else begin
      ivl_end = state_reg.ivl_cnt >= state_reg.ivl_len - 32'h00000001;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DFM_NUM_TERM; g++) begin : g_edge
      assign rise_edge[g] = !state_reg.prev[g] && state_reg.status[g];
      assign fall_edge[g] = state_reg.prev[g] && !state_reg.status[g];
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < `DFM_NUM_CH; c++) begin : g_chan
      logic [2:0] pt;
      logic [2:0] dt;
      assign pt = pulse_term(2'(c), state_reg.ctrl.fast);
      assign dt = dir_term(2'(c), state_reg.ctrl.fast);
      assign chan_on[c] = chan_active(2'(c), state_reg.ctrl);
      // Polarity is chosen per channel, not per terminal, so the
      // fast variant's second channel keeps its own setting.
      assign chan_hit[c] = chan_on[c] && (state_reg.ctrl.fall[c]
                                          ? fall_edge[pt]
                                          : rise_edge[pt]); // R5
      assign chan_dir[c] = state_reg.status[dt]; // R9
    end
  endgenerate

  always_comb begin
    dfm_pkg::dfm_word_t rd_word;
    logic [1:0]         ch;
    rd_word = 32'h00000000;
    ch = 2'h0;
    state_next = state_reg;

    state_next.prev   = state_reg.status;
    state_next.status = ~term_in; // R12

    // The interval counter only restarts; pulse and reference
    // counters free-run across boundaries so no edge is lost.
    if (ivl_end) begin
      state_next.ivl_cnt = 32'h00000000; // R17
    end else begin
      state_next.ivl_cnt = state_reg.ivl_cnt + 32'h00000001;
    end

    // Each carry of the phase accumulator is one 48 MHz tick.
    state_next.ref_ph = 24'(state_reg.ref_ph + `DFM_REF_INC); // R16
    if (state_next.ref_ph < state_reg.ref_ph) begin
      state_next.ref_cnt = state_reg.ref_cnt + 32'h00000001; // R4
    end

    if (ivl_end) begin
      state_next.phase = dfm_pkg::DFM_LATCH;
    end else begin
      state_next.phase = dfm_pkg::DFM_RUN;
    end

    for (int i = 0; i < `DFM_NUM_CH; i++) begin
      if (chan_hit[i]) begin
        state_next.pulse[i] = state_reg.pulse[i] + 32'h00000001; // R8
        if (state_reg.ctrl.recip[i] || state_reg.ctrl.fast) begin
          state_next.last_edge_ref[i] = state_reg.ref_cnt; // R5
        end
        // Quadrature: other phase high at this edge means forward.
        state_next.dir[i] = chan_dir[i]; // R9
      end
    end

    if (ivl_end) begin
      for (int i = 0; i < `DFM_NUM_CH; i++) begin
        state_next.snap[i] = take_snap(state_reg.pulse[i],
                                       state_reg.prev_pulse[i],
                                       state_reg.last_edge_ref[i],
                                       state_reg.prev_ref[i],
                                       state_reg.ivl_cnt,
                                       state_reg.dir[i]);
        state_next.prev_pulse[i] = state_reg.pulse[i]; // R2
        state_next.prev_ref[i] = state_reg.last_edge_ref[i];
      end
    end

    if (wr) begin
      case (addr)
        `DFM_REG_CTRL: begin
          state_next.ctrl = ctrl_unpack(wdata); // R14
        end
        `DFM_REG_IVL_LEN: begin
          // A zero length would stretch an interval to 2^32 cycles.
          if (wdata == 32'h00000000) begin
            state_next.ivl_len = 32'h00000001;
          end else begin
            state_next.ivl_len = wdata;
          end
        end
        `DFM_REG_IRQ_CLR: begin
          state_next.irq_stat = state_reg.irq_stat & ~wdata[3:0];
        end
        `DFM_REG_IRQ_EN: begin
          state_next.irq_en = wdata[3:0];
        end
        default: begin
        end
      endcase
    end

    // Applied after the clear, so an interval end in the same cycle
    // is never lost to software.
    if (ivl_end) begin
      state_next.irq_stat = state_next.irq_stat | chan_on;
    end

    if (rd) begin
      case (addr)
        `DFM_REG_CTRL: begin
          rd_word = ctrl_pack(state_reg.ctrl);
        end
        `DFM_REG_IVL_LEN: begin
          rd_word = state_reg.ivl_len;
        end
        `DFM_REG_STATUS_IN: begin
          rd_word = {24'h000000, state_reg.status}; // R11
        end
        `DFM_REG_IRQ_STAT: begin
          rd_word = {28'h0000000, state_reg.irq_stat};
        end
        `DFM_REG_IRQ_EN: begin
          rd_word = {28'h0000000, state_reg.irq_en};
        end
        `DFM_REG_DIR: begin
          for (int i = 0; i < `DFM_NUM_CH; i++) begin
            rd_word[i]     = state_reg.snap[i].dir;
            rd_word[8 + i] = state_reg.snap[i].valid;
          end
        end
        default: begin
          if (is_chan_addr(addr)) begin
            ch = chan_of_addr(addr);
            rd_word = chan_field(state_reg.snap[ch], addr[3:2]);
          end
        end
      endcase
    end

    state_next.rdata = rd_word;
    state_next.irq = |(state_next.irq_stat & state_next.irq_en);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.ivl_len <= `DFM_IVL_LEN_RESET;
      state_reg.ctrl <= dfm_pkg::dfm_ctrl_s'(`DFM_CTRL_RESET);
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata      = state_reg.rdata;
  assign status_out = state_reg.status;
  assign irq        = state_reg.irq;
endmodule
`default_nettype wire

/* rtl/dfm_defines.svh */
// Constants for the digital input frequency meter.
`ifndef DFM_DEFINES_SVH
`define DFM_DEFINES_SVH
`define DFM_NUM_TERM        8
`define DFM_NUM_CH          4
`define DFM_CNT_W           32
`define DFM_ADDR_W          8
`define DFM_CLK_HZ          200000000
`define DFM_REF_HZ          48000000
`define DFM_FAST_1IN_NS     1000000
`define DFM_FAST_2IN_NS     2000000
`define DFM_CLK_NS          5
`define DFM_FAST_1IN_CYC    (`DFM_FAST_1IN_NS / `DFM_CLK_NS)
`define DFM_FAST_2IN_CYC    (`DFM_FAST_2IN_NS / `DFM_CLK_NS)
`define DFM_IVL_LEN_RESET   32'h0000C350
`define DFM_REF_PH_W        24
`define DFM_REF_INC         24'h3D70A4
`define DFM_REG_CTRL        8'h00
`define DFM_REG_IVL_LEN     8'h04
`define DFM_REG_STATUS_IN   8'h08
`define DFM_REG_IRQ_STAT    8'h0C
`define DFM_REG_IRQ_CLR     8'h10
`define DFM_REG_IRQ_EN      8'h14
`define DFM_REG_DIR         8'h18
`define DFM_REG_CH_BASE     8'h20
`define DFM_CH_STRIDE       8'h10
`define DFM_CH_PULSE        2'h0
`define DFM_CH_REFCNT       2'h1
`define DFM_CH_INTERVAL     2'h2
`define DFM_CH_EDGE_REF     2'h3
`define DFM_CTRL_EN_LSB     0
`define DFM_CTRL_FALL_LSB   4
`define DFM_CTRL_RECIP_LSB  8
`define DFM_CTRL_FAST_LSB   12
`define DFM_CTRL_FAST2_BIT  13
`define DFM_CTRL_RESET      32'h00000000
`endif

/* rtl/dfm_pkg.sv */
// Types for the digital input frequency meter.
`include "dfm_defines.svh"
package dfm_pkg;
  typedef logic [`DFM_CNT_W-1:0] dfm_word_t;
  typedef struct packed {
    dfm_word_t pulse;
    dfm_word_t refcnt;
    dfm_word_t interval;
    dfm_word_t edge_ref;
    logic      valid;
    logic      dir;
  } dfm_snap_s;
  typedef struct packed {
    logic [3:0] en;
    logic [3:0] fall;
    logic [3:0] recip;
    logic       fast;
    logic       fast_two;
  } dfm_ctrl_s;
  typedef enum logic [0:0] {DFM_RUN, DFM_LATCH} dfm_phase_e;
  typedef struct packed {
    dfm_ctrl_s                   ctrl;
    dfm_word_t                   ivl_len;
    dfm_word_t                   ivl_cnt;
    logic [`DFM_REF_PH_W-1:0]    ref_ph;
    dfm_word_t                   ref_cnt;
    logic [7:0]                  status;
    logic [7:0]                  prev;
    dfm_word_t [3:0]             pulse;
    dfm_word_t [3:0]             last_edge_ref;
    dfm_word_t [3:0]             prev_pulse;
    dfm_word_t [3:0]             prev_ref;
    dfm_snap_s [3:0]             snap;
    logic [3:0]                  dir;
    logic [3:0]                  irq_stat;
    logic [3:0]                  irq_en;
    logic                        irq;
    dfm_word_t                   rdata;
    dfm_phase_e                  phase;
  } dfm_state_s;
endpackage

/* verification/dfm_meter_props.sv */
// Port-level assertions for the frequency meter.
`timescale 1ns/1ps
`default_nettype none
module dfm_meter_props (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [7:0]  term_in,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [7:0]  status_out,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_len_wr0; wr && addr == 8'h04 && wdata == 32'h0; endsequence
  sequence s_len_wr; wr && addr == 8'h04 && wdata != 32'h0; endsequence
  sequence s_len_rd; rd && addr == 8'h04; endsequence
  sequence s_ctl_wr; wr && addr == 8'h00; endsequence
  sequence s_ctl_rd; rd && addr == 8'h00; endsequence
  AST_STATUS_INV: assert property (!$past(reset) |-> status_out == ~$past(term_in)) else $error("status not inverted input");
  AST_RD_IDLE: assert property (!$past(reset) && !$past(rd) |-> rdata == 32'h0) else $error("read data outside read slot");
  AST_STATUS_RD: assert property (rd && addr == 8'h08 |=> rdata == {24'h0, $past(status_out)}) else $error("status read mismatch");
  AST_UNMAPPED: assert property (rd && addr == 8'hFC |=> rdata == 32'h0) else $error("unmapped read not zero");
  AST_MASK: assert property (wr && addr == 8'h14 && wdata[3:0] == 4'h0 |-> ##[1:3] !irq) else $error("masked interrupt stays high");
  AST_LEN_RB: assert property (s_len_wr ##1 s_len_rd |=> rdata == $past(wdata, 2)) else $error("interval length readback");
  AST_LEN_ZERO: assert property (s_len_wr0 ##1 s_len_rd |=> rdata == 32'h1) else $error("zero interval not forced to one");
  AST_CTRL_RB: assert property (s_ctl_wr ##1 s_ctl_rd |=> rdata[13:0] == $past(wdata[13:0], 2)) else $error("control readback");
endmodule
bind dfm_meter dfm_meter_props i_props (.core_clk(core_clk), .reset(reset), .term_in(term_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .status_out(status_out), .irq(irq));
`default_nettype wire

/* verification/dfm_quad_src.sv */
// Quadrature pulse source standing on a channel's two terminals.
`timescale 1ns/1ps
`default_nettype none
module dfm_quad_src (
  input  wire logic       core_clk,
  input  wire logic       run,
  input  wire logic       lag,
  input  wire logic [7:0] quarter,
  output logic            pulse_lvl,
  output logic            dir_lvl
);
  logic [7:0] cnt = 8'h00;
  logic [1:0] ph  = 2'h0;
  always @(posedge core_clk) begin
    if (run && cnt + 8'h01 >= quarter) begin
      cnt <= 8'h00;
      ph  <= ph + 2'h1;
    end else begin
      cnt <= run ? cnt + 8'h01 : 8'h00;
    end
  end
  // Stopped terminals float up through the pull-up, reading as logic zero.
  assign pulse_lvl = run ? ph[1] : 1'b1;
  assign dir_lvl   = run ? (ph[1] ^ ph[0] ^ lag) : 1'b1;
endmodule
`default_nettype wire

/* verification/dfm_meter_tb.sv */
// Register-level testbench for the frequency meter.
`timescale 1ns/1ps
`default_nettype none
module dfm_meter_tb;
  logic core_clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
  logic run = 1'b0, lag = 1'b0, qa, qb, irq;
  logic [7:0] addr = 8'h00, hi = 8'hFF, status_out;
  logic [31:0] wdata = 32'h0, rdata, got;
  int bad_count = 0, n_compared = 0;
  always #2.5 core_clk = ~core_clk;
  dfm_quad_src i_src (.core_clk(core_clk), .run(run), .lag(lag),
    .quarter(8'h0C), .pulse_lvl(qa), .dir_lvl(qb));
  dfm_meter i_dut (.core_clk(core_clk), .reset(reset),
    .term_in({hi[7:5], qb, hi[3:1], qa}), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .status_out(status_out), .irq(irq));
  task automatic finish_test();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] exp, logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Called right after a rising edge; a write leaves wr up so that a
  // following call can take the very next cycle.
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    wr <= 1'b1; rd <= 1'b0; addr <= a; wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic rd_reg(logic [7:0] a);
    rd <= 1'b1; wr <= 1'b0; addr <= a;
    @(posedge core_clk); rd <= 1'b0;
    @(negedge core_clk); got = rdata;
    @(posedge core_clk);
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge core_clk);
    if (irq !== 1'b1) begin bad_count++; finish_test(); end
    wr_reg(8'h10, 32'h1);
    rd_reg(8'h0C); check("irq_stat", 32'h0, got & 32'h1);
  endtask
  task automatic measure(logic l);
    logic [31:0] p, t;
    lag <= l; run <= 1'b1;
    wait_irq(); wait_irq(); wait_irq();
    rd_reg(8'h20); p = got;
    if (got !== 32'd20 && got !== 32'd21) check("pulses", 32'd20, got);
    rd_reg(8'h24);
    // Span between last edges is p periods of 48 cycles, 0.24 ticks each.
    t = p * 32'd1152 / 32'd100;
    if (got !== t && got !== t + 32'd1) check("ref_ticks", t, got);
    rd_reg(8'h28); check("interval", 32'd1000, got);
    rd_reg(8'h18); check("dir_valid", {20'h0, 4'h1, 7'h0, ~l}, got & 32'hF0F);
  endtask
  initial begin
    logic [7:0] pat[3] = '{8'h00, 8'hA5, 8'hFF};
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    foreach (pat[i]) begin
      hi <= pat[i] | 8'h11;
      repeat (3) @(posedge core_clk);
      rd_reg(8'h08); check("status", {24'h0, ~(pat[i] | 8'h11)}, got);
    end
    rd_reg(8'hFC); check("unmapped", 32'h0, got);
    wr_reg(8'h04, 32'h0); rd_reg(8'h04); check("len_zero", 32'h1, got);
    wr_reg(8'h04, 32'd1000); rd_reg(8'h04); check("len", 32'd1000, got);
    wr_reg(8'h14, 32'h1);
    wr_reg(8'h00, 32'h101); rd_reg(8'h00); check("ctrl", 32'h101, got);
    measure(1'b0);
    measure(1'b1);
    run <= 1'b0;
    wait_irq(); wait_irq();
    rd_reg(8'h18); check("valid", 32'h0, got & 32'h100);
    wr_reg(8'h14, 32'h0);
    rd_reg(8'h14); check("irq_en", 32'h0, got);
    repeat (3000) @(posedge core_clk);
    check("irq_masked", 32'h0, {31'h0, irq});
    finish_test();
  end
endmodule
`default_nettype wire
